// ===== verilog/drs_pkg.sv
// drs_pkg: constants, strap layout and states of the drive ready and strap select block
`default_nettype none
package drs_pkg;
    // register byte offsets
    localparam logic [3:0] DRS_CFG_OFS = 4'h0; // strap register
    localparam logic [3:0] DRS_STAT_OFS = 4'h4; // state register
    // strap bit positions in the strap register
    localparam int DRS_SINGLE_BIT = 0;
    localparam int DRS_ADDR_LSB = 1; // four address straps, bits 1..4
    localparam int DRS_SEL_LOAD_BIT = 5;
    localparam int DRS_MOT_LOAD_BIT = 6;
    localparam int DRS_LOAD_EN_BIT = 7;
    localparam int DRS_OCC_FN_BIT = 8;
    localparam int DRS_ENG_FN_BIT = 9;
    localparam int DRS_IND_A_BIT = 10;
    localparam int DRS_IND_LATCH_BIT = 11;
    localparam int DRS_IND_RDY_BIT = 12;
    localparam int DRS_MOT_LATCH_BIT = 13;
    localparam int DRS_HICAP_BIT = 14; // high-capacity model select
    localparam int DRS_CFG_W = 15;
    // strap reset value: address 0, select-gated loading, occupancy function
    localparam logic [DRS_CFG_W-1:0] DRS_CFG_RST = 15'h01A2;
    // axi responses
    localparam logic [1:0] DRS_RESP_OK = 2'h0;
    localparam logic [1:0] DRS_RESP_ERR = 2'h2;
    // timing, milliseconds and clock rate
    localparam int DRS_CLK_KHZ = 20000;
    localparam int DRS_READY_HICAP_MS = 730;
    localparam int DRS_READY_STD_MS = 800;
    localparam int DRS_RATED_MS = 400;
    localparam int DRS_TMR_W = 24;
    // longest times round down: whole ms times the rate are exact
    localparam int DRS_READY_HICAP_CYC = DRS_READY_HICAP_MS * DRS_CLK_KHZ;
    localparam int DRS_READY_STD_CYC = DRS_READY_STD_MS * DRS_CLK_KHZ;
    localparam int DRS_RATED_CYC = DRS_RATED_MS * DRS_CLK_KHZ;
    // index pulses needed after half speed
    localparam logic [1:0] DRS_IDX_PRE = 2'h1;
    localparam logic [1:0] DRS_IDX_READY = 2'h2;
    // readiness states
    typedef enum logic [1:0] {
        DRS_STOPPED,
        DRS_PRE_READY,
        DRS_READY
    } drs_state_t;
endpackage
`default_nettype wire

// ===== verilog/drs_drive_ready.sv
// drs_drive_ready: ready detection, strap decoding and axi4-lite strap registers
`timescale 1ns/1ps
`default_nettype none
module drs_drive_ready
    import drs_pkg::*;
#(
    parameter logic [DRS_TMR_W-1:0] READY_HICAP_LIMIT = DRS_TMR_W'(DRS_READY_HICAP_CYC),
    parameter logic [DRS_TMR_W-1:0] READY_STD_LIMIT = DRS_TMR_W'(DRS_READY_STD_CYC),
    parameter logic [DRS_TMR_W-1:0] RATED_LIMIT = DRS_TMR_W'(DRS_RATED_CYC)
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // drive sensing
    input wire logic power_good,
    input wire logic disk_present,
    input wire logic half_speed,
    input wire logic rated_speed,
    input wire logic index_pulse,
    // host interface lines, active low
    input wire logic [3:0] unit_select_n,
    input wire logic run_request_n,
    input wire logic shared_request_n,
    output logic ready_n,
    // drive actuators
    output logic spindle_on,
    output logic head_load,
    output logic indicator_on
);
    // whole state of the block
    typedef struct packed {
        drs_state_t st;                // readiness state
        logic [1:0] idx_cnt;           // index pulses since half speed
        logic idx_prev;                // index edge detect
        logic sel_prev;                // matched select edge detect
        logic occ_latch;               // occupancy latch
        logic [DRS_TMR_W-1:0] tmr;     // time since spindle start
        logic late;                    // ready missed its deadline
        logic rated_ok;                // rated speed seen in time
        logic [DRS_CFG_W-1:0] cfg;     // strap register
        logic aw_held;                 // write address taken
        logic [3:0] aw_addr;
        logic w_held;                  // write data taken
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic ready_n;
        logic spindle_on;
        logic head_load;
        logic indicator_on;
    } drs_regs_t;

    drs_regs_t r;
    drs_regs_t next_r;

    // one-hot address straps against active-low select lines
    function automatic logic drs_match(input logic [3:0] straps, input logic [3:0] sel_n);
        drs_match = |(straps & ~sel_n);
    endfunction

    // strap and line decode
    logic single_drive_strap;
    logic matched;
    logic effective;
    logic run_req;
    logic in_use;
    logic engage_req;
    logic rdy_any;
    logic ready_now;
    logic late_event;             // deadline reached while not ready
    logic indicator;
    logic [DRS_TMR_W-1:0] ready_limit;
    logic [31:0] status_word;

    always_comb begin
        single_drive_strap = r.cfg[DRS_SINGLE_BIT];
        matched = drs_match(r.cfg[DRS_ADDR_LSB +: 4], unit_select_n);
        effective = matched | single_drive_strap;
        run_req = ~run_request_n;
        // shared line split by its two function straps
        in_use = r.cfg[DRS_OCC_FN_BIT] & ~shared_request_n;
        engage_req = r.cfg[DRS_ENG_FN_BIT] & ~shared_request_n;
        rdy_any = (r.st != DRS_STOPPED);
        ready_now = (r.st == DRS_READY);
        ready_limit = r.cfg[DRS_HICAP_BIT] ? READY_HICAP_LIMIT : READY_STD_LIMIT;
        late_event = r.spindle_on & (r.tmr == ready_limit) & ~ready_now;
        // indicator selection uses plain select only
        if (r.cfg[DRS_IND_RDY_BIT]) begin
            indicator = matched & ready_now;
        end else if (r.cfg[DRS_OCC_FN_BIT] & r.cfg[DRS_IND_A_BIT]) begin
            indicator = r.cfg[DRS_IND_LATCH_BIT] ? r.occ_latch : in_use;
        end else if (r.cfg[DRS_OCC_FN_BIT]) begin
            indicator = matched | (r.cfg[DRS_IND_LATCH_BIT] ? r.occ_latch : in_use);
        end else begin
            indicator = matched;
        end
        status_word = 32'h0000_0000;
        status_word[1:0] = r.st;
        status_word[3:2] = r.idx_cnt;
        status_word[4] = r.spindle_on;
        status_word[5] = r.head_load;
        status_word[6] = r.indicator_on;
        status_word[7] = r.occ_latch;
        status_word[8] = r.late;
        status_word[9] = r.rated_ok;
    end

    // next state of the whole block
    always_comb begin
        next_r = r;
        next_r.idx_prev = index_pulse;
        next_r.sel_prev = matched;
        // leading edge of matched select loads the occupancy latch
        if (matched & ~r.sel_prev) begin
            next_r.occ_latch = in_use;
        end
        // readiness from disk, speed and index count
        if (!power_good || !disk_present || !half_speed) begin
            next_r.st = DRS_STOPPED;
            next_r.idx_cnt = 2'h0;
        end else if (index_pulse & ~r.idx_prev) begin
            case (r.st)
                DRS_STOPPED: begin
                    next_r.st = DRS_PRE_READY;
                    next_r.idx_cnt = DRS_IDX_PRE;
                end
                DRS_PRE_READY: begin
                    next_r.st = DRS_READY;
                    next_r.idx_cnt = DRS_IDX_READY;
                end
                default: begin
                    next_r.st = r.st;
                end
            endcase
        end
        // spindle command
        next_r.spindle_on = run_req | (r.cfg[DRS_MOT_LATCH_BIT] & indicator);
        next_r.indicator_on = indicator;
        // head-load conditions
        next_r.head_load = rdy_any & (
            (r.cfg[DRS_LOAD_EN_BIT] & r.cfg[DRS_SEL_LOAD_BIT] & effective) |
            (r.cfg[DRS_LOAD_EN_BIT] & r.cfg[DRS_MOT_LOAD_BIT] & run_req) |
            (engage_req & effective));
        // ready line driven only while selected
        next_r.ready_n = ~(ready_now & effective);
        // spin-up watch: deadline and rated-speed window
        if (!r.spindle_on) begin
            next_r.tmr = '0;
        end else if (r.tmr != ready_limit) begin
            next_r.tmr = r.tmr + DRS_TMR_W'(1);
        end
        if (late_event) begin
            next_r.late = 1'b1;
        end
        if (!r.spindle_on) begin
            next_r.rated_ok = 1'b0;
        end else if (rated_speed && r.tmr <= RATED_LIMIT) begin
            next_r.rated_ok = 1'b1;
        end
        // axi write: address and data in either order
        if (s_axi_awvalid & ~r.aw_held & ~r.bvalid) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~r.w_held & ~r.bvalid) begin
            next_r.w_held = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (r.aw_held & r.w_held) begin
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            if (r.aw_addr == DRS_CFG_OFS) begin
                next_r.bresp = DRS_RESP_OK;
                if (r.w_strb[0]) begin
                    next_r.cfg[7:0] = r.w_data[7:0];
                end
                if (r.w_strb[1]) begin
                    next_r.cfg[DRS_CFG_W-1:8] = r.w_data[DRS_CFG_W-1:8];
                end
                // writing the straps clears the late flag; a deadline expiring now wins
                next_r.late = late_event;
            end else if (r.aw_addr == DRS_STAT_OFS) begin
                next_r.bresp = DRS_RESP_OK; // state register ignores writes
            end else begin
                next_r.bresp = DRS_RESP_ERR;
            end
        end else if (r.bvalid & s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        // axi read
        if (s_axi_arvalid & ~r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = DRS_RESP_OK;
            if (s_axi_araddr == DRS_CFG_OFS) begin
                next_r.rdata = {17'h0_0000, r.cfg};
            end else if (s_axi_araddr == DRS_STAT_OFS) begin
                next_r.rdata = status_word;
            end else begin
                next_r.rdata = 32'h0000_0000;
                next_r.rresp = DRS_RESP_ERR;
            end
        end else if (r.rvalid & s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
    end

    // register the whole state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.st <= DRS_STOPPED;
            r.cfg <= DRS_CFG_RST;
            r.ready_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign s_axi_awready = ~r.aw_held & ~r.bvalid;
    assign s_axi_wready = ~r.w_held & ~r.bvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = ~r.rvalid;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign ready_n = r.ready_n;
    assign spindle_on = r.spindle_on;
    assign head_load = r.head_load;
    assign indicator_on = r.indicator_on;

    // checks
    a_ready_needs_disk: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.st == DRS_READY) |-> $past(power_good) && $past(disk_present) && $past(half_speed))
        else $error("ready without power, disk or speed");
    a_ready_two_index: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r.st == DRS_READY) |-> $past(r.st) == DRS_PRE_READY && r.idx_cnt == 2'h2)
        else $error("ready reached without two index pulses");
    a_pre_one_index: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.st == DRS_STOPPED && half_speed && disk_present && power_good
         && index_pulse && !r.idx_prev) |=> r.st == DRS_PRE_READY)
        else $error("pre-ready missed after first index");
    a_loss_drops: assert property (@(posedge aclk) disable iff (!aresetn)
        (!disk_present || !half_speed) |=> r.st == DRS_STOPPED && r.idx_cnt == 2'h0)
        else $error("readiness held after disk loss or slowdown");
    a_spindle_plain: assert property (@(posedge aclk) disable iff (!aresetn)
        !r.cfg[DRS_MOT_LATCH_BIT] |=> spindle_on == !$past(run_request_n))
        else $error("spindle not following run request");
    a_spindle_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.cfg[DRS_MOT_LATCH_BIT] && indicator) |=> spindle_on)
        else $error("spindle idle with indicator lit");
    a_ready_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        !effective |=> ready_n)
        else $error("ready driven while not selected");
    a_load_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        (!r.cfg[DRS_LOAD_EN_BIT] && !r.cfg[DRS_ENG_FN_BIT]) |=> !head_load)
        else $error("head loaded with option straps disabled");
    a_load_needs_rdy: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.st == DRS_STOPPED) |=> !head_load)
        else $error("head loaded while not ready or pre-ready");
    a_occ_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        (matched && !r.sel_prev) |=> r.occ_latch == $past(in_use))
        else $error("occupancy latch missed select edge");
    a_late_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r.late) |-> $past(r.tmr) == $past(ready_limit) && $past(r.st) != DRS_READY)
        else $error("late flag without expired deadline");
endmodule // drs_drive_ready
`default_nettype wire

// ===== sim/drs_mech_model.sv
// drs_mech_model: spindle, disk and index sensor seen by the ready logic
`timescale 1ns/1ps
`default_nettype none
module drs_mech_model #(
    parameter int HALF_CYC = 20, // spin cycles to pass half speed
    parameter int RATED_CYC = 40 // spin cycles to reach rated speed
) (
    input wire logic aclk,
    input wire logic spindle_on, // motor drive from the block
    input wire logic disk_in, // a disk sits in the drive
    output logic half_speed,
    output logic rated_speed,
    output logic index_pulse
);
    int spin = 0; // cycles since spin-up began
    // the disk stops at once when the drive or the disk goes
    always @(posedge aclk) begin
        spin <= (spindle_on && disk_in) ? spin + 1 : 0;
    end
    assign half_speed = spin >= HALF_CYC;
    assign rated_speed = spin >= RATED_CYC;
    // two-cycle index every 32 cycles; with no disk the sensor reads steady
    assign index_pulse = !disk_in || (spin >= 32 && spin[4:0] < 2);
endmodule // drs_mech_model
`default_nettype wire

// ===== sim/tb_top.sv
// tb_top: self-checking bench for the drive ready and strap select block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import drs_pkg::*;
;
    typedef struct {logic [33:0] exp; logic [33:0] mask; string what;} drs_note_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic power_good = 1'b1, disk_present = 1'b1, probe = 1'b0;
    logic half_speed, rated_speed, index_pulse;
    logic [3:0] unit_select_n = 4'hF; // host lines idle high
    logic run_request_n = 1'b1, shared_request_n = 1'b1;
    logic ready_n, spindle_on, head_load, indicator_on;
    logic [15:0] lfsr = 16'h0037; // random source, seed 55
    int fails = 0, comparisons = 0;
    drs_note_t notes[$]; // expected results, oldest first

    always #25 aclk = ~aclk;

    drs_drive_ready #(.READY_HICAP_LIMIT(24'h00_00C8), .READY_STD_LIMIT(24'h00_00DC),
        .RATED_LIMIT(24'h00_0064)) drs_drive_ready_i (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .power_good, .disk_present, .half_speed,
        .rated_speed, .index_pulse, .unit_select_n, .run_request_n, .shared_request_n,
        .ready_n, .spindle_on, .head_load, .indicator_on);

    drs_mech_model drs_mech_model_i (.aclk, .spindle_on, .disk_in(disk_present),
        .half_speed, .rated_speed, .index_pulse);

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // report and count one comparison
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic note(input string what, input logic [33:0] exp, input logic [33:0] mask);
        notes.push_back('{exp, mask, what});
    endtask

    // one bus transfer; handshakes are judged on values settled before the edge
    task automatic xfer(input logic wr, input logic [3:0] addr, input logic [31:0] data,
        input logic [33:0] exp, input logic [33:0] mask, input string what);
        int n;
        logic ha, hw, hb, hr, hd;
        note(what, exp, mask);
        s_axi_awaddr <= addr;
        s_axi_araddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        n = 0;
        hb = 1'b0;
        hr = 1'b0;
        while (!(hb || hr) && n < 100) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid && s_axi_bready;
            hr = s_axi_rvalid && s_axi_rready;
            hd = s_axi_arvalid && s_axi_arready;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hd) s_axi_arvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
            n++;
        end
        if (n >= 100) fails++;
        @(posedge aclk);
    endtask

    task automatic rd_stat(input logic [31:0] mask, input logic [31:0] exp, input string what);
        xfer(1'b0, DRS_STAT_OFS, 32'h0000_0000, {DRS_RESP_OK, exp}, {2'b11, mask}, what);
    endtask

    // note the pin vector and flag it for the watcher for one cycle
    task automatic probe_pins(input logic [3:0] e, input string what);
        note(what, {30'h0000_0000, e}, {34{1'b1}});
        probe <= 1'b1;
        @(posedge aclk);
        probe <= 1'b0;
    endtask

    // set straps (random filler above the strap field), then lines, then look
    task automatic apply(input logic [14:0] cfg, input int sel, input logic sh0,
        input logic sh1, input logic run, input logic [3:0] e, input string what);
        xfer(1'b1, DRS_CFG_OFS, {lfsr, lfsr[0], cfg}, {DRS_RESP_OK, 32'h0000_0000},
            {2'b11, 32'h0000_0000}, "cfg write");
        lfsr = lfsr_next(lfsr);
        unit_select_n <= 4'hF;
        shared_request_n <= !sh0;
        repeat (2) @(posedge aclk);
        if (sel < 4) unit_select_n <= ~(4'h1 << sel);
        repeat (2) @(posedge aclk);
        shared_request_n <= !sh1;
        run_request_n <= !run;
        repeat (6) @(posedge aclk);
        probe_pins(e, what);
    endtask

    task automatic wait_index();
        int n;
        n = 0;
        while (index_pulse !== 1'b0 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        while (index_pulse !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 400) fails++;
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watcher: each result meets the oldest note
    always @(negedge aclk) begin
        drs_note_t n;
        logic [33:0] seen;
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready) || probe) begin
            seen = {30'h0000_0000, ready_n, spindle_on, head_load, indicator_on};
            if (s_axi_rvalid && s_axi_rready) seen = {s_axi_rresp, s_axi_rdata};
            if (s_axi_bvalid && s_axi_bready) seen = {s_axi_bresp, 32'h0000_0000};
            if (notes.size() == 0) begin
                fails++;
                $display("BAD result with no note expected none seen %h", seen);
            end else begin
                n = notes.pop_front();
                check(n.what, seen & n.mask, n.exp & n.mask);
            end
        end
    end

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        probe_pins(4'b1000, "idle pins");
        xfer(1'b0, DRS_CFG_OFS, 32'h0000_0000, {DRS_RESP_OK, 32'h0000_01A2}, {34{1'b1}}, "cfg");
        rd_stat(32'h0000_03FF, 32'h0000_0000, "status after reset");
        xfer(1'b0, 4'h8, 32'h0000_0000, {DRS_RESP_ERR, 32'h0000_0000}, {34{1'b1}}, "hole rd");
        xfer(1'b1, 4'hC, 32'hFFFF_FFFF, {DRS_RESP_ERR, 32'h0000_0000}, {34{1'b1}}, "hole wr");
        xfer(1'b1, DRS_STAT_OFS, 32'hFFFF_FFFF, {DRS_RESP_OK, 32'h0000_0000}, {34{1'b1}}, "ro");
        xfer(1'b0, DRS_CFG_OFS, 32'h0000_0000, {DRS_RESP_OK, 32'h0000_01A2}, {34{1'b1}}, "cfg");
        // spin up with no unit selected
        run_request_n <= 1'b0;
        wait_index();
        repeat (3) @(posedge aclk);
        rd_stat(32'h0000_000F, 32'h0000_0005, "pre-ready");
        wait_index();
        repeat (3) @(posedge aclk);
        rd_stat(32'h0000_03FF, 32'h0000_021A, "ready");
        // one address per drive, four drives at most on the chain
        for (int a = 0; a < 4; a++) begin
            for (int s = 0; s < 5; s++) begin
                apply(15'(2 << a), s, 1'b0, 1'b0, 1'b1, (s == a) ? 4'b0101 : 4'b1100,
                    "address select");
            end
        end
        apply(15'h0005, 4, 1'b0, 1'b0, 1'b1, 4'b0100, "single");
        apply(15'h1004, 1, 1'b0, 1'b0, 1'b1, 4'b0101, "ind sel2");
        apply(15'h0504, 4, 1'b1, 1'b1, 1'b1, 4'b1101, "ind sel3");
        apply(15'h0D04, 1, 1'b1, 1'b0, 1'b1, 4'b0101, "latch set");
        apply(15'h0904, 4, 1'b0, 1'b0, 1'b1, 4'b1101, "ind sel6");
        apply(15'h0D04, 1, 1'b0, 1'b1, 1'b1, 4'b0100, "latch clear");
        apply(15'h0104, 4, 1'b1, 1'b1, 1'b1, 4'b1101, "ind sel5");
        apply(15'h00A4, 1, 1'b0, 1'b0, 1'b1, 4'b0111, "sel load");
        apply(15'h00A4, 4, 1'b0, 1'b0, 1'b1, 4'b1100, "sel load off");
        apply(15'h00A5, 4, 1'b0, 1'b0, 1'b1, 4'b0110, "sel load single");
        apply(15'h0024, 1, 1'b0, 1'b0, 1'b1, 4'b0101, "no option");
        apply(15'h00C4, 4, 1'b0, 1'b0, 1'b1, 4'b1110, "motor load");
        apply(15'h0044, 4, 1'b0, 1'b0, 1'b1, 4'b1100, "motor no option");
        apply(15'h0204, 1, 1'b1, 1'b1, 1'b1, 4'b0111, "engage on");
        apply(15'h0204, 1, 1'b0, 1'b0, 1'b1, 4'b0101, "engage off");
        apply(15'h0004, 4, 1'b1, 1'b1, 1'b1, 4'b1100, "no function");
        apply(15'h0304, 4, 1'b1, 1'b1, 1'b1, 4'b1101, "both functions");
        apply(15'h0305, 4, 1'b1, 1'b1, 1'b1, 4'b0111, "both single");
        apply(15'h2504, 4, 1'b1, 1'b1, 1'b0, 4'b1101, "motor latch");
        apply(15'h0004, 1, 1'b0, 1'b0, 1'b0, 4'b1001, "motor stop");
        rd_stat(32'h0000_001F, 32'h0000_0000, "stopped");
        // spin up again, then pull the disk long enough to miss the deadline
        run_request_n <= 1'b0;
        wait_index();
        wait_index();
        repeat (3) @(posedge aclk);
        rd_stat(32'h0000_000F, 32'h0000_000A, "ready again");
        disk_present <= 1'b0;
        repeat (200) @(posedge aclk);
        rd_stat(32'h0000_010F, 32'h0000_0100, "disk out late");
        disk_present <= 1'b1;
        wait_index();
        wait_index();
        repeat (3) @(posedge aclk);
        xfer(1'b1, DRS_CFG_OFS, 32'h0000_0004, {DRS_RESP_OK, 32'h0000_0000},
            {2'b11, 32'h0000_0000}, "cfg rewrite");
        rd_stat(32'h0000_010F, 32'h0000_000A, "late cleared");
        // power loss drops readiness, its return counts indexes afresh
        power_good <= 1'b0;
        repeat (2) @(posedge aclk);
        rd_stat(32'h0000_000F, 32'h0000_0000, "power off");
        power_good <= 1'b1;
        wait_index();
        repeat (3) @(posedge aclk);
        rd_stat(32'h0000_000F, 32'h0000_0005, "power back");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
